// ### rtl/pfr_pkg.sv
/*
 Constants for the transmit packet framer: register map, control bits,
 reset values, framing characters, polynomials and state codes.
 Assumes a 32-bit register port with byte addresses.
*/
package pfr_pkg;
   // Framing characters
   localparam logic [7:0] FLAG_BYTE = 8'h7E;
   localparam logic [7:0] ESC_BYTE = 8'h7D;
   localparam logic [7:0] ESC_XOR = 8'h20;
   // Register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_GAP = 8'h04;
   localparam logic [7:0] ADDR_HWM = 8'h08;
   localparam logic [7:0] ADDR_LWM = 8'h0C;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   // Control field positions and reset values
   localparam int CTL_CRC32 = 0;
   localparam int CTL_FCS_EN = 1;
   localparam int CTL_ERR_INS = 2;
   localparam int CTL_SCR_EN = 3;
   localparam logic [3:0] CTRL_RST = 4'hB;
   localparam logic [7:0] GAP_RST = 8'h00;
   localparam int HWM_RST = 192;
   localparam int LWM_RST = 128;
   // Status field positions
   localparam int STAT_OVR = 16;
   localparam int STAT_UND = 17;
   // Reflected polynomials, bits sent low first
   localparam logic [15:0] CRC16_POLY = 16'h8408;
   localparam logic [31:0] CRC32_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [42:0] SCR_INIT = 43'h7FFFFFFFFFF;
   // Line byte sequencer
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_DATA = 2'h1,
      ST_FCS = 2'h2,
      ST_ABORT = 2'h3
   } pfr_state_e;
endpackage

// ### rtl/pfr_tx_framer.sv
/*
 Transmit packet framer: 16-bit packet write port into a byte FIFO, line
 byte sequencer with flags, gap, FCS, stuffing, abort and scrambling.
 Assumes the line clock and overhead strobe come from another domain and
 are oversampled here; overhead marks a line slot with no payload.
*/
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
module pfr_tx_framer #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Packet write side, first byte in [15:8]
   input wire logic [15:0] pkt_data_in,
   input wire logic pkt_wr_in,
   input wire logic pkt_sop_in,
   input wire logic pkt_eop_in,
   input wire logic pkt_odd_in,
   output logic transmit_space_available_out,
   // Line side
   input wire logic line_side_clock_in,
   input wire logic overhead_slot_in,
   output logic [7:0] line_byte_out,
   output logic line_byte_valid_out
);
   if (DEPTH < 4 || DEPTH != (1 << AW)) begin : g_bad_depth
      $error("pfr_tx_framer: DEPTH must be 2**AW and at least 4");
   end

   localparam logic [AW:0] DEPTH_L = (AW + 1)'(DEPTH);

   // Escape test is shared by data and FCS bytes
   function automatic logic needs_esc(input logic [7:0] b);
      return (b == pfr_pkg::FLAG_BYTE) || (b == pfr_pkg::ESC_BYTE);
   endfunction

   // Bytewise CRC, bits taken low first
   function automatic logic [31:0] crc_f(input logic [31:0] c, input logic [7:0] d, input logic w32);
      logic [31:0] t;
      t = c;
      for (int i = 0; i < 8; i++) begin
         if (w32) begin
            t = (t >> 1) ^ ((t[0] ^ d[i]) ? pfr_pkg::CRC32_POLY : 32'h00000000);
         end else begin
            t = {16'h0000, (t[15:0] >> 1) ^ ((t[0] ^ d[i]) ? pfr_pkg::CRC16_POLY : 16'h0000)};
         end
      end
      return t;
   endfunction

   // Self-synchronous x^43+1, first line bit is byte bit 7
   function automatic logic [50:0] scr_f(input logic [42:0] s, input logic [7:0] d);
      logic [42:0] t;
      logic [7:0] o;
      t = s;
      o = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         o[i] = d[i] ^ t[42];
         t = {t[41:0], o[i]};
      end
      return {t, o};
   endfunction

   logic [3:0] ctrl_q;
   logic [7:0] gap_cfg_q;
   logic [AW:0] hwm_q, lwm_q;
   logic ovr_q, und_q;
   logic [9:0] mem [DEPTH];
   logic [AW:0] wp_q, rp_q, fill, free_sp;
   logic [1:0] nbytes;
   logic ovr_evt, und_evt, empty;
   logic [9:0] head;
   logic lck1_q, lck2_q, lck3_q, oh1_q, oh2_q;
   logic edge_w, slot;
   pfr_pkg::pfr_state_e st_q, st_d;
   logic [7:0] gap_q, gap_d;
   logic esc_pend_q, esc_pend_d;
   logic [7:0] esc_byte_q, esc_byte_d;
   logic [31:0] crc_q, crc_d, fcs_word;
   logic [1:0] idx_q, idx_d, idx_last;
   logic [7:0] raw_d, raw_q;
   logic pop;
   logic [42:0] scr_q;
   logic [50:0] scr_res;

   // Register writes; sticky clears lose to a same-cycle event
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= pfr_pkg::CTRL_RST;
         gap_cfg_q <= pfr_pkg::GAP_RST;
         hwm_q <= (AW + 1)'(pfr_pkg::HWM_RST);
         lwm_q <= (AW + 1)'(pfr_pkg::LWM_RST);
         ovr_q <= 1'b0;
         und_q <= 1'b0;
      end else begin
         if (reg_wr_in && reg_addr_in == pfr_pkg::ADDR_CTRL) begin
            ctrl_q <= reg_wdata_in[3:0];
         end
         if (reg_wr_in && reg_addr_in == pfr_pkg::ADDR_GAP) begin
            gap_cfg_q <= reg_wdata_in[7:0];
         end
         if (reg_wr_in && reg_addr_in == pfr_pkg::ADDR_HWM) begin
            hwm_q <= reg_wdata_in[AW:0];
         end
         if (reg_wr_in && reg_addr_in == pfr_pkg::ADDR_LWM) begin
            lwm_q <= reg_wdata_in[AW:0];
         end
         ovr_q <= ovr_evt | (ovr_q & ~(reg_wr_in && reg_addr_in == pfr_pkg::ADDR_STAT
                                       && reg_wdata_in[pfr_pkg::STAT_OVR]));
         und_q <= und_evt | (und_q & ~(reg_wr_in && reg_addr_in == pfr_pkg::ADDR_STAT
                                       && reg_wdata_in[pfr_pkg::STAT_UND]));
      end
   end

   // Read data stand one cycle, zero otherwise and for unmapped addresses
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 32'h00000000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            pfr_pkg::ADDR_CTRL: reg_rdata_out <= {28'h0000000, ctrl_q};
            pfr_pkg::ADDR_GAP: reg_rdata_out <= {24'h000000, gap_cfg_q};
            pfr_pkg::ADDR_HWM: reg_rdata_out <= 32'(hwm_q);
            pfr_pkg::ADDR_LWM: reg_rdata_out <= 32'(lwm_q);
            pfr_pkg::ADDR_STAT: reg_rdata_out <= {14'h0000, und_q, ovr_q, 16'(fill)};
            default: reg_rdata_out <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_out <= 32'h00000000;
      end
   end

   // Fill level from pointers, one extra bit tells full from empty
   assign fill = wp_q - rp_q;
   assign free_sp = DEPTH_L - fill;
   assign empty = (fill == '0);
   assign nbytes = (pkt_eop_in && pkt_odd_in) ? 2'h1 : 2'h2;
   // A word that does not fit is dropped whole; the packet is not aborted
   assign ovr_evt = pkt_wr_in && (free_sp < (AW + 1)'(nbytes));
   assign head = mem[rp_q[AW-1:0]];

   // Write side: two bytes per word, one for an odd last word, tagged with start and end marks
   always_ff @(posedge clk_sys_in) begin
      if (pkt_wr_in && !ovr_evt) begin
         mem[wp_q[AW-1:0]] <= {pkt_sop_in, pkt_eop_in && pkt_odd_in, pkt_data_in[15:8]};
         if (nbytes == 2'h2) begin
            mem[wp_q[AW-1:0] + AW'(1)] <= {1'b0, pkt_eop_in, pkt_data_in[7:0]};
         end
      end
   end

   // Pointers; read pointer moves one byte per line slot at most
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (pkt_wr_in && !ovr_evt) begin
            wp_q <= wp_q + (AW + 1)'(nbytes);
         end
         if (pop) begin
            rp_q <= rp_q + (AW + 1)'(1);
         end
      end
   end

   // Space indication with hysteresis so the writer does not chatter
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         transmit_space_available_out <= 1'b1;
      end else if (fill > hwm_q) begin
         transmit_space_available_out <= 1'b0;
      end else if (fill < lwm_q) begin
         transmit_space_available_out <= 1'b1;
      end
   end

   // Two-stage synchronisers; edge taken from second and third stage
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         lck1_q <= 1'b0;
         lck2_q <= 1'b0;
         lck3_q <= 1'b0;
         oh1_q <= 1'b0;
         oh2_q <= 1'b0;
      end else begin
         lck1_q <= line_side_clock_in;
         lck2_q <= lck1_q;
         lck3_q <= lck2_q;
         oh1_q <= overhead_slot_in;
         oh2_q <= oh1_q;
      end
   end
   assign edge_w = lck2_q && !lck3_q;
   // Overhead slots carry nothing from here; the sequencer just holds
   assign slot = edge_w && !oh2_q;

   // FCS word: complement of CRC, inverted again for error insertion
   assign fcs_word = ~crc_q ^ {32{ctrl_q[pfr_pkg::CTL_ERR_INS]}};
   assign idx_last = ctrl_q[pfr_pkg::CTL_CRC32] ? 2'h3 : 2'h1;

   // Line byte sequencer, next values
   always_comb begin
      logic [7:0] b;
      b = 8'h00;
      st_d = st_q;
      gap_d = gap_q;
      esc_pend_d = 1'b0;
      esc_byte_d = esc_byte_q;
      crc_d = crc_q;
      idx_d = idx_q;
      raw_d = pfr_pkg::FLAG_BYTE;
      pop = 1'b0;
      und_evt = 1'b0;
      if (!slot) begin
         pop = 1'b0;
      end else if (esc_pend_q) begin
         raw_d = esc_byte_q;
      end else begin
         case (st_q)
            pfr_pkg::ST_IDLE: begin
               raw_d = pfr_pkg::FLAG_BYTE;
               if (!empty && !head[9]) begin
                  pop = 1'b1;
               end else if (gap_q != 8'h00) begin
                  gap_d = gap_q - 8'h01;
               end else if (!empty) begin
                  st_d = pfr_pkg::ST_DATA;
                  crc_d = pfr_pkg::CRC_INIT;
               end
            end
            pfr_pkg::ST_DATA: begin
               if (empty) begin
                  raw_d = pfr_pkg::ESC_BYTE;
                  st_d = pfr_pkg::ST_ABORT;
                  und_evt = 1'b1;
               end else begin
                  pop = 1'b1;
                  b = head[7:0];
                  crc_d = crc_f(crc_q, b, ctrl_q[pfr_pkg::CTL_CRC32]);
                  if (head[8]) begin
                     idx_d = 2'h0;
                     if (ctrl_q[pfr_pkg::CTL_FCS_EN]) begin
                        st_d = pfr_pkg::ST_FCS;
                     end else begin
                        st_d = pfr_pkg::ST_IDLE;
                        gap_d = gap_cfg_q;
                     end
                  end
               end
            end
            pfr_pkg::ST_FCS: begin
               // Low byte first: x^highest coefficient leaves first on the line
               b = fcs_word[8*idx_q +: 8];
               idx_d = idx_q + 2'h1;
               if (idx_q == idx_last) begin
                  st_d = pfr_pkg::ST_IDLE;
                  gap_d = gap_cfg_q;
               end
            end
            pfr_pkg::ST_ABORT: begin
               raw_d = pfr_pkg::FLAG_BYTE;
               st_d = pfr_pkg::ST_IDLE;
               gap_d = gap_cfg_q;
            end
            default: begin
               st_d = pfr_pkg::ST_IDLE;
            end
         endcase
         if (st_q == pfr_pkg::ST_FCS || (st_q == pfr_pkg::ST_DATA && !empty)) begin
            raw_d = b;
            if (needs_esc(b)) begin
               raw_d = pfr_pkg::ESC_BYTE;
               esc_pend_d = 1'b1;
               esc_byte_d = b ^ pfr_pkg::ESC_XOR;
            end
         end
      end
   end

   // Sequencer state, advanced only on payload slots
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= pfr_pkg::ST_IDLE;
         gap_q <= 8'h00;
         esc_pend_q <= 1'b0;
         esc_byte_q <= 8'h00;
         crc_q <= pfr_pkg::CRC_INIT;
         idx_q <= 2'h0;
         raw_q <= pfr_pkg::FLAG_BYTE;
      end else if (slot) begin
         st_q <= st_d;
         gap_q <= gap_d;
         esc_pend_q <= esc_pend_d;
         esc_byte_q <= esc_byte_d;
         crc_q <= crc_d;
         idx_q <= idx_d;
         raw_q <= raw_d;
      end
   end

   // Scrambler and line output; bypass leaves state untouched
   assign scr_res = scr_f(scr_q, raw_d);
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         scr_q <= pfr_pkg::SCR_INIT;
         line_byte_out <= pfr_pkg::FLAG_BYTE;
         line_byte_valid_out <= 1'b0;
      end else begin
         line_byte_valid_out <= slot;
         if (slot && ctrl_q[pfr_pkg::CTL_SCR_EN]) begin
            scr_q <= scr_res[50:8];
            line_byte_out <= scr_res[7:0];
         end else if (slot) begin
            line_byte_out <= raw_d;
         end
      end
   end

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   AST_IDLE_FLAG: assert property (slot && !esc_pend_q && st_q == pfr_pkg::ST_IDLE |=> raw_q == 8'h7E)
      else $error("idle slot did not send a flag");
   AST_ABORT_SEQ: assert property (slot && !esc_pend_q && st_q == pfr_pkg::ST_DATA && empty
         |=> raw_q == 8'h7D && st_q == pfr_pkg::ST_ABORT && und_q)
      else $error("underflow did not start abort");
   AST_OVR_DROP: assert property (ovr_evt |=> wp_q == $past(wp_q) && ovr_q)
      else $error("overrun word was written");
   AST_FILL_MAX: assert property (fill <= DEPTH_L)
      else $error("fill level beyond capacity");
   AST_SPACE_OFF: assert property (fill > hwm_q |=> !transmit_space_available_out)
      else $error("space indication above high watermark");
   AST_SPACE_ON: assert property (fill < lwm_q && fill <= hwm_q |=> transmit_space_available_out)
      else $error("space indication missing below low watermark");
   AST_STUFF: assert property (slot && esc_pend_q |=> raw_q == $past(esc_byte_q)
         && (raw_q == 8'h5E || raw_q == 8'h5D) && $past(raw_q) == 8'h7D)
      else $error("escape pair malformed");
   AST_BYPASS: assert property (slot && !ctrl_q[pfr_pkg::CTL_SCR_EN] |=> line_byte_out == raw_q)
      else $error("bypass altered the byte");
   AST_OH_GAP: assert property (edge_w && oh2_q |=> !line_byte_valid_out && $stable(st_q))
      else $error("byte sent in overhead slot");
   AST_FCS_END: assert property (slot && !esc_pend_q && st_q == pfr_pkg::ST_FCS && idx_q == idx_last
         |=> st_q == pfr_pkg::ST_IDLE && gap_q == gap_cfg_q)
      else $error("FCS length wrong");
   AST_NO_FCS: assert property (slot && !esc_pend_q && st_q == pfr_pkg::ST_DATA && !empty && head[8]
         && !ctrl_q[pfr_pkg::CTL_FCS_EN] |=> st_q == pfr_pkg::ST_IDLE)
      else $error("FCS sent while disabled");

   COV_ABORT: cover property (slot && st_q == pfr_pkg::ST_ABORT);
   COV_FCS32: cover property (slot && st_q == pfr_pkg::ST_FCS && idx_q == 2'h3);
   COV_DISCARD: cover property (pop && st_q == pfr_pkg::ST_IDLE);
   COV_OVR: cover property (ovr_evt);
endmodule

// ### bench/pfr_link_model.sv
/*
 Link layer model: writes packet pieces into the framer as 16-bit words.
 Assumes its task is called from a bench running on the same clock.
*/
`timescale 1ns/10ps
module pfr_link_model (
   // Clock
   input wire logic clk_in,
   // Room indication from the framer
   input wire logic space_in,
   // Packet word port
   output logic [15:0] data_out,
   output logic wr_out,
   output logic sop_out,
   output logic eop_out,
   output logic odd_out
);
   // Quiet port from time zero
   initial begin
      data_out = 16'h0000;
      wr_out = 1'b0;
      sop_out = 1'b0;
      eop_out = 1'b0;
      odd_out = 1'b0;
   end

   // One piece of a packet; obey low lets a test overrun the FIFO on purpose
   task automatic send(input logic [7:0] q[$], input logic sop, input logic eop, input logic obey);
      int i;
      int n;
      n = q.size();
      @(posedge clk_in);
      for (i = 0; i < n; i += 2) begin
         while (obey && space_in !== 1'b1) begin
            wr_out <= 1'b0;
            @(posedge clk_in);
         end
         data_out <= {q[i], (i + 1 < n) ? q[i + 1] : ~q[i]};
         wr_out <= 1'b1;
         sop_out <= sop && i == 0;
         eop_out <= eop && i + 2 >= n;
         odd_out <= eop && i + 1 == n;
         @(posedge clk_in);
      end
      wr_out <= 1'b0;
      sop_out <= 1'b0;
      eop_out <= 1'b0;
      odd_out <= 1'b0;
      // Released bus must not look like the last word
      data_out <= ~data_out;
   endtask
endmodule

// ### bench/pfr_tx_framer_tb.sv
/*
 Self-checking bench for the transmit packet framer: registers, idle flags,
 FCS modes, gap, underflow abort and overrun.
 Assumes the link model beside it and a free-running line clock.
*/
`timescale 1ns/10ps
module pfr_tx_framer_tb;
   logic clk_sys_in;
   logic rst_in;
   logic line_clk;
   logic ovh;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [15:0] pkt_data;
   logic pkt_wr, pkt_sop, pkt_eop, pkt_odd;
   logic space;
   logic [7:0] line_byte;
   logic line_valid;
   logic [7:0] rx_q[$];
   // Descrambler on the capture side, off unless a test needs it
   logic descr = 1'b0;
   logic [42:0] dh = '1;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   localparam int LIMIT = 40000;

   pfr_tx_framer uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
      .pkt_data_in(pkt_data), .pkt_wr_in(pkt_wr), .pkt_sop_in(pkt_sop), .pkt_eop_in(pkt_eop),
      .pkt_odd_in(pkt_odd), .transmit_space_available_out(space), .line_side_clock_in(line_clk),
      .overhead_slot_in(ovh), .line_byte_out(line_byte), .line_byte_valid_out(line_valid));

   pfr_link_model link (.clk_in(clk_sys_in), .space_in(space), .data_out(pkt_data), .wr_out(pkt_wr),
      .sop_out(pkt_sop), .eop_out(pkt_eop), .odd_out(pkt_odd));

   // System clock, 50 MHz
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   // Line clock, 160 ns, phase unrelated to the system clock
   initial begin
      line_clk = 1'b0;
      #7;
      forever #80 line_clk = ~line_clk;
   end
   // Line byte capture and hang guard
   always @(posedge clk_sys_in) begin
      if (line_valid === 1'b1) begin
         rx_q.push_back(line_byte);
      end
      cyc++;
      if (cyc == LIMIT) begin
         fail_count++;
         test_done();
      end
   end

   task automatic test_done;
      if (fail_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // Bounded wait; a missing byte comes back unknown and fails its compare
   task automatic get_byte(output logic [7:0] b);
      int n;
      int i;
      logic o;
      n = 0;
      while (rx_q.size() == 0 && n < 300) begin
         @(posedge clk_sys_in);
         n++;
      end
      b = 'x;
      if (rx_q.size() > 0) begin
         b = rx_q.pop_front();
         // Self-synchronous x^43+1 inverse, bit 7 first on the line
         if (descr) begin
            for (i = 7; i >= 0; i--) begin
               o = b[i] ^ dh[42];
               dh = {dh[41:0], b[i]};
               b[i] = o;
            end
         end
      end
   endtask

   task automatic skip_flags(output logic [7:0] b, output int n);
      n = 0;
      get_byte(b);
      while (b === 8'h7E && n < 400) begin
         n++;
         get_byte(b);
      end
   endtask

   // Overhead strobe moved well away from a line edge
   task automatic set_ovh(input logic v);
      @(negedge line_clk);
      @(posedge clk_sys_in);
      ovh <= v;
   endtask

   task automatic check_frame(input logic [7:0] pl[$], input logic [3:0] m, input int nflag);
      logic [31:0] crc;
      logic [7:0] r[$];
      logic [7:0] e[$];
      logic [7:0] b;
      int i;
      int n;
      r = pl;
      crc = m[0] ? 32'hFFFFFFFF : 32'h0000FFFF;
      foreach (pl[j]) begin
         crc = crc ^ {24'h000000, pl[j]};
         for (i = 0; i < 8; i++) begin
            crc = crc[0] ? (crc >> 1) ^ (m[0] ? 32'hEDB88320 : 32'h00008408) : crc >> 1;
         end
      end
      crc = m[2] ? crc : ~crc;
      for (i = 0; i < (m[1] ? (m[0] ? 4 : 2) : 0); i++) begin
         r.push_back(crc[8 * i +: 8]);
      end
      foreach (r[j]) begin
         if (r[j] == 8'h7E || r[j] == 8'h7D) begin
            e.push_back(8'h7D);
            e.push_back(r[j] ^ 8'h20);
         end else begin
            e.push_back(r[j]);
         end
      end
      skip_flags(b, n);
      if (nflag >= 0) begin
         chk(n, nflag);
      end
      foreach (e[j]) begin
         if (j > 0) begin
            get_byte(b);
         end
         chk(b, e[j]);
      end
      get_byte(b);
      chk(b, 8'h7E);
   endtask

   // Reset values, scrambler start state, plain idle flags
   task automatic t_reset;
      logic [7:0] b;
      int i;
      for (i = 0; i < 5; i++) begin
         get_byte(b);
         chk(b, 8'h81);
      end
      rd_chk(pfr_pkg::ADDR_CTRL, 32'h0000000B);
      rd_chk(pfr_pkg::ADDR_GAP, 32'h00000000);
      rd_chk(pfr_pkg::ADDR_HWM, 32'h000000C0);
      rd_chk(pfr_pkg::ADDR_LWM, 32'h00000080);
      rd_chk(pfr_pkg::ADDR_STAT, 32'h00000000);
      rd_chk(8'h14, 32'h00000000);
      wr_reg(pfr_pkg::ADDR_CTRL, 32'h00000002);
      repeat (40) @(posedge clk_sys_in);
      rx_q.delete();
      for (i = 0; i < 4; i++) begin
         get_byte(b);
         chk(b, 8'h7E);
      end
   endtask

   // Every FCS mode over a payload that needs stuffing, odd length
   task automatic t_modes;
      logic [3:0] m[5] = '{4'h2, 4'h3, 4'h7, 4'h0, 4'h6};
      logic [7:0] p[$] = {8'h41, 8'h7E, 8'h7D, 8'h7E, 8'h5A};
      foreach (m[i]) begin
         wr_reg(pfr_pkg::ADDR_CTRL, {28'h0000000, m[i]});
         link.send(p, 1'b1, 1'b1, 1'b1);
         check_frame(p, m[i], -1);
      end
   endtask

   // Flags between back-to-back packets
   task automatic t_gap;
      logic [7:0] p[$] = {8'h21, 8'h22, 8'h23};
      logic [7:0] g[2] = '{8'h00, 8'h03};
      wr_reg(pfr_pkg::ADDR_CTRL, 32'h00000003);
      foreach (g[i]) begin
         wr_reg(pfr_pkg::ADDR_GAP, {24'h000000, g[i]});
         link.send(p, 1'b1, 1'b1, 1'b1);
         link.send(p, 1'b1, 1'b1, 1'b1);
         check_frame(p, 4'h3, -1);
         check_frame(p, 4'h3, int'(g[i]));
      end
   endtask

   // FIFO runs dry mid-packet, the tail is discarded, next packet is clean
   task automatic t_underflow;
      logic [7:0] p[$] = {8'h55, 8'h66};
      logic [7:0] b;
      int n;
      link.send({8'h11, 8'h22}, 1'b1, 1'b0, 1'b1);
      skip_flags(b, n);
      chk(b, 8'h11);
      get_byte(b);
      chk(b, 8'h22);
      get_byte(b);
      chk(b, 8'h7D);
      get_byte(b);
      chk(b, 8'h7E);
      rd_chk(pfr_pkg::ADDR_STAT, 32'h00020000);
      wr_reg(pfr_pkg::ADDR_STAT, 32'h00030000);
      rd_chk(pfr_pkg::ADDR_STAT, 32'h00000000);
      link.send({8'h33, 8'h44}, 1'b0, 1'b1, 1'b1);
      link.send(p, 1'b1, 1'b1, 1'b1);
      check_frame(p, 4'h3, -1);
   endtask

   // Scrambled frame checked after descrambling; 6 bytes let the descrambler lock
   task automatic t_scramble;
      logic [7:0] p[$] = {8'h7E, 8'h12, 8'hC3};
      logic [7:0] b;
      wr_reg(pfr_pkg::ADDR_CTRL, 32'h0000000B);
      repeat (40) @(posedge clk_sys_in);
      rx_q.delete();
      descr = 1'b1;
      repeat (6) get_byte(b);
      link.send(p, 1'b1, 1'b1, 1'b1);
      check_frame(p, 4'hB, -1);
      descr = 1'b0;
      wr_reg(pfr_pkg::ADDR_CTRL, 32'h00000003);
   endtask

   // Line held in overhead while the FIFO is overfilled; packet goes out without the dropped word
   task automatic t_overrun;
      logic [7:0] p[$];
      int i;
      for (i = 0; i < 256; i++) begin
         p.push_back(8'(i % 64));
      end
      set_ovh(1'b1);
      repeat (10) @(posedge clk_sys_in);
      rx_q.delete();
      link.send(p, 1'b1, 1'b0, 1'b0);
      link.send({8'h01, 8'h02}, 1'b0, 1'b0, 1'b0);
      rd_chk(pfr_pkg::ADDR_STAT, 32'h00010100);
      chk({31'h0, space}, 32'h0);
      chk(rx_q.size(), 0);
      set_ovh(1'b0);
      link.send({8'h03, 8'h04}, 1'b0, 1'b1, 1'b1);
      p.push_back(8'h03);
      p.push_back(8'h04);
      check_frame(p, 4'h3, -1);
   endtask

   // Main sequence
   initial begin
      rst_in = 1'b1;
      ovh = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_reset();
      t_modes();
      t_gap();
      t_underflow();
      t_scramble();
      t_overrun();
      test_done();
   end
endmodule
